// file: wss_pkg.sv
// package of constants and types for the waveform sequence slot registers
package wss_pkg;
   // register map (byte addresses in the device register space)
   localparam logic [7:0] WSS_ADDR_TRIGGER = 8'h0c;  // control register holding the trigger bit
   localparam logic [7:0] WSS_ADDR_FIRST = 8'h0f;    // first sequence slot
   localparam logic [7:0] WSS_ADDR_SLOT4 = 8'h12;    // sequence_slot_four
   localparam logic [7:0] WSS_ADDR_SLOT5 = 8'h13;    // sequence_slot_five
   localparam logic [7:0] WSS_ADDR_LAST = 8'h16;     // last sequence slot
   // reset values
   localparam logic [7:0] WSS_SLOT_RST = 8'h00;
   localparam logic [7:0] WSS_RDATA_RST = 8'h00;
   // slot bookkeeping
   localparam int WSS_NUM_SLOTS = 8;
   localparam logic [2:0] WSS_IDX_FIRST = 3'h0;
   localparam logic [2:0] WSS_IDX_LAST = 3'h7;
   localparam logic [2:0] WSS_IDX_FOUR = 3'h3;       // slot at 0x12 counted from 0x0f
   localparam logic [2:0] WSS_IDX_FIVE = 3'h4;       // slot at 0x13
   localparam logic [2:0] WSS_IDX_ONE = 3'h1;
   localparam logic [2:0] WSS_IDX_GAP = 3'h2;        // slots four and five are not in ext_slots
   localparam logic [6:0] WSS_VALUE_STOP = 7'h00;    // zero value ends the sequence
   // timing: one idle step
   localparam int WSS_STEP_TIME_MS = 10;
   localparam int WSS_CLK_MHZ = 125;
   localparam int WSS_STEP_CYCLES_DEF = WSS_STEP_TIME_MS * 1000 * WSS_CLK_MHZ;
   localparam int WSS_STEP_CNT_W = 21;
   localparam logic [WSS_STEP_CNT_W-1:0] WSS_STEP_CNT_ZERO = 21'h0;
   localparam logic [6:0] WSS_IDLE_ONE = 7'h01;
   // one sequence slot: mode bit and seven-bit value
   typedef struct packed {
      logic delay_select;  // 1: value is idle steps, 0: value is waveform id
      logic [6:0] value;
   } wss_slot_t;
   // sequencer states
   typedef enum logic [1:0] {
      WSS_ST_IDLE = 2'b00,
      WSS_ST_FETCH = 2'b01,
      WSS_ST_PLAY = 2'b10,
      WSS_ST_WAIT = 2'b11
   } wss_state_t;
endpackage

// file: wss_slots.sv
// sequence slots four and five with the eight-slot waveform sequencer
`timescale 1ns/1ps
// How it works
// - mode bit one: value is idle period
// - idle lasts value times 10 ms
// - mode bit zero: value is waveform id
// - id indexes the internal waveform library
// - trigger starts sequencing at slot 0x0f
// - after waveform ends, advance, play non-zero
// - stop at zero value or eight slots
module wss_slots import wss_pkg::*; #(
   parameter int STEP_CYCLES = WSS_STEP_CYCLES_DEF  // cycles in one 10 ms idle step
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port from the serial control bus engine
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // the six slots held elsewhere, in slot order without four and five
   input wire wss_slot_t [5:0] ext_slots,
   // playback control
   input wire logic trigger,
   input wire logic wave_done,
   output logic play_start,
   output logic [6:0] wave_id,
   output logic idle_active,
   output logic seq_busy,
   output logic [2:0] slot_index,
   // register contents for the rest of the device
   output wss_slot_t slot_four,
   output wss_slot_t slot_five
);

   // register storage
   wss_slot_t slot_four_ff;  // sequence_slot_four
   wss_slot_t slot_five_ff;  // sequence_slot_five
   logic [7:0] rdata_ff;     // captured read data
   logic hit_ff;             // read hit flag

   // sequencer state
   wss_state_t state_ff;
   wss_state_t nxt_state;
   logic [2:0] idx_ff;                     // current slot, 0 means 0x0f
   logic [2:0] nxt_idx;
   logic [6:0] idle_left_ff;               // idle steps still to go
   logic [6:0] nxt_idle_left;
   logic [WSS_STEP_CNT_W-1:0] step_cnt_ff; // cycles inside current step
   logic [WSS_STEP_CNT_W-1:0] nxt_step_cnt;
   logic play_ff;                          // one-cycle play request
   logic nxt_play;
   logic [6:0] id_ff;                      // id sent to the library
   logic [6:0] nxt_id;
   logic idle_ff;                          // high through a timed idle slot
   logic busy_ff;                          // high from trigger until the sequence stops

   // address decode
   // only the two slot addresses are decoded here; the rest of the map lives elsewhere
   wire logic sel_four = (reg_addr == WSS_ADDR_SLOT4);
   wire logic sel_five = (reg_addr == WSS_ADDR_SLOT5);
   wire logic wr_four = reg_wr && sel_four;
   wire logic wr_five = reg_wr && sel_five;
   wire logic [7:0] rd_mux = sel_four ? slot_four_ff : (sel_five ? slot_five_ff : WSS_RDATA_RST);

   // pick the slot the sequencer points at
   // slots past the local pair sit two places lower in the shared array
   wire wss_slot_t cur_slot =
      (idx_ff == WSS_IDX_FOUR) ? slot_four_ff :
      (idx_ff == WSS_IDX_FIVE) ? slot_five_ff :
      (idx_ff < WSS_IDX_FOUR) ? ext_slots[idx_ff] :
      ext_slots[idx_ff - WSS_IDX_GAP];

   // step timing; the step count is a parameter so simulations can shrink it
   // the counter width covers a full 10 ms step at the core clock rate
   wire logic step_end = (step_cnt_ff == WSS_STEP_CNT_W'(STEP_CYCLES - 1));
   wire logic last_slot = (idx_ff == WSS_IDX_LAST);
   wire logic is_stop = (cur_slot.value == WSS_VALUE_STOP);

   // register writes; a write during playback takes effect at the next fetch
   // no byte other than the two slots is ever written here
   always_ff @(posedge core_clk) begin
      if (rst) begin
         slot_four_ff <= WSS_SLOT_RST;
         slot_five_ff <= WSS_SLOT_RST;
      end else begin
         if (wr_four) begin
            slot_four_ff <= reg_wdata;
         end
         if (wr_five) begin
            slot_five_ff <= reg_wdata;
         end
      end
   end

   // read data captured on the read strobe, unmapped addresses read zero
   // the hit flag lets the bus engine merge this read data with other blocks
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_ff <= WSS_RDATA_RST;
         hit_ff <= 1'b0;
      end else if (reg_rd) begin
         rdata_ff <= rd_mux;
         hit_ff <= sel_four || sel_five;
      end
   end

   // sequencer next-state logic
   // defaults hold every register except the play request, which defaults low, so each branch names only what moves
   always_comb begin
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_idle_left = idle_left_ff;
      nxt_step_cnt = step_cnt_ff;
      nxt_play = 1'b0;
      nxt_id = id_ff;
      case (state_ff)
         WSS_ST_IDLE: begin
            // a trigger while busy is ignored; only this state looks at it
            if (trigger) begin
               nxt_idx = WSS_IDX_FIRST;
               nxt_state = WSS_ST_FETCH;
            end
         end
         WSS_ST_FETCH: begin
            // a slot written during playback is seen here when next fetched
            if (is_stop) begin
               // zero value ends playback whatever the mode bit
               nxt_state = WSS_ST_IDLE;
            end else if (cur_slot.delay_select) begin
               // idle slot: nothing is driven for value steps
               nxt_idle_left = cur_slot.value;
               nxt_step_cnt = WSS_STEP_CNT_ZERO;
               nxt_state = WSS_ST_WAIT;
            end else begin
               // waveform slot: the value is the library index
               nxt_id = cur_slot.value;
               nxt_play = 1'b1;
               nxt_state = WSS_ST_PLAY;
            end
         end
         WSS_ST_PLAY: begin
            // wave_done outside this state is ignored
            if (wave_done) begin
               if (last_slot) begin
                  nxt_state = WSS_ST_IDLE;
               end else begin
                  nxt_idx = idx_ff + WSS_IDX_ONE;
                  nxt_state = WSS_ST_FETCH;
               end
            end
         end
         WSS_ST_WAIT: begin
            // count steps of STEP_CYCLES each
            // the counter restarts for every step; the last step ends the slot
            if (step_end) begin
               nxt_step_cnt = WSS_STEP_CNT_ZERO;
               nxt_idle_left = idle_left_ff - WSS_IDLE_ONE;
               if (idle_left_ff == WSS_IDLE_ONE) begin
                  if (last_slot) begin
                     nxt_state = WSS_ST_IDLE;
                  end else begin
                     nxt_idx = idx_ff + WSS_IDX_ONE;
                     nxt_state = WSS_ST_FETCH;
                  end
               end
            end else begin
               nxt_step_cnt = step_cnt_ff + WSS_STEP_CNT_W'(1);
            end
         end
         default: begin
            nxt_state = WSS_ST_IDLE;
         end
      endcase
   end

   // sequencer registers
   // the play pulse drops on its own because nxt_play defaults low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= WSS_ST_IDLE;
         idx_ff <= WSS_IDX_FIRST;
         idle_left_ff <= WSS_VALUE_STOP;
         step_cnt_ff <= WSS_STEP_CNT_ZERO;
         play_ff <= 1'b0;
         id_ff <= WSS_VALUE_STOP;
      end else begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         idle_left_ff <= nxt_idle_left;
         step_cnt_ff <= nxt_step_cnt;
         play_ff <= nxt_play;
         id_ff <= nxt_id;
      end
   end

   // status flags registered from the next state, so they line up with
   // state_ff while each output still comes straight from a flip-flop
   wire logic nxt_idle = (nxt_state == WSS_ST_WAIT);
   wire logic nxt_busy = (nxt_state != WSS_ST_IDLE);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         idle_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         idle_ff <= nxt_idle;
         busy_ff <= nxt_busy;
      end
   end

   // outputs, all straight from flip-flops
   assign reg_rdata = rdata_ff;
   assign reg_hit = hit_ff;
   assign play_start = play_ff;
   assign wave_id = id_ff;
   assign idle_active = idle_ff;
   assign seq_busy = busy_ff;
   assign slot_index = idx_ff;
   // the register contents go out unchanged to the rest of the device
   assign slot_four = slot_four_ff;
   assign slot_five = slot_five_ff;

endmodule // wss_slots

// file: wss_slots_checker.sv
// checker for the sequence slot block
`timescale 1ns/1ps
module wss_slots_checker import wss_pkg::*; (
   // clock, reset, register port
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_hit,
   // playback
   input wire logic trigger,
   input wire logic wave_done,
   input wire logic play_start,
   input wire logic [6:0] wave_id,
   input wire logic idle_active,
   input wire logic seq_busy,
   input wire logic [2:0] slot_index,
   input wire wss_slot_t slot_four
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   wire hit_addr = reg_addr inside {WSS_ADDR_SLOT4, WSS_ADDR_SLOT5};
   // done while playing; a fetch moves the index, so stable leaves it out
   sequence s_done;
      seq_busy && wave_done && !idle_active && $stable(slot_index) && !$rose(seq_busy);
   endsequence
   property p_hit; reg_rd |=> reg_hit == $past(hit_addr); endproperty
   a_hit: assert property (p_hit) else $error("read hit wrong");
   property p_go; trigger && !seq_busy |=> seq_busy && slot_index == WSS_IDX_FIRST; endproperty
   a_go: assert property (p_go) else $error("bad start");
   property p_quiet; idle_active |-> !play_start; endproperty
   a_quiet: assert property (p_quiet) else $error("play in idle");
   property p_gap; $rose(idle_active) |-> idle_active[*8]; endproperty
   a_gap: assert property (p_gap) else $error("idle too short");
   property p_id; play_start && slot_index == WSS_IDX_FOUR |-> wave_id == slot_four.value; endproperty
   a_id: assert property (p_id) else $error("wrong id");
   property p_mode; play_start && slot_index == WSS_IDX_FOUR |-> !slot_four.delay_select; endproperty
   a_mode: assert property (p_mode) else $error("idle slot played");
   property p_next; s_done ##0 slot_index != WSS_IDX_LAST |=> slot_index == $past(slot_index) + 3'h1; endproperty
   a_next: assert property (p_next) else $error("no advance");
   property p_end; s_done ##0 slot_index == WSS_IDX_LAST |=> !seq_busy; endproperty
   a_end: assert property (p_end) else $error("no stop");
   c_play: cover property (play_start);
   c_idle: cover property ($rose(idle_active));
   c_stop: cover property ($fell(seq_busy));
endmodule // wss_slots_checker
bind wss_slots wss_slots_checker u_chk (
   .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_hit(reg_hit),
   .trigger(trigger), .wave_done(wave_done), .play_start(play_start), .wave_id(wave_id),
   .idle_active(idle_active), .seq_busy(seq_busy), .slot_index(slot_index),
   .slot_four(slot_four)
);

// file: wss_slots_bench.sv
// self-checking bench for the sequence slot block
`timescale 1ns/1ps
module wss_slots_bench import wss_pkg::*;;
   localparam int STEP = 8; // short idle step keeps the run brief
   logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, trigger = 0, wave_done = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_hit, play_start, idle_active, seq_busy;
   logic [6:0] wave_id;
   logic [2:0] slot_index;
   wss_slot_t [5:0] ext_slots = '0;
   wss_slot_t slot_four, slot_five, m4 = '0, m5 = '0; // m4, m5: expected contents
   int seed = 38, bad_count = 0, n_compared = 0, n;
   wss_slots #(.STEP_CYCLES(STEP)) i_dut (
      .core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_hit(reg_hit), .ext_slots(ext_slots),
      .trigger(trigger), .wave_done(wave_done), .play_start(play_start), .wave_id(wave_id),
      .idle_active(idle_active), .seq_busy(seq_busy), .slot_index(slot_index),
      .slot_four(slot_four), .slot_five(slot_five)
   );
   initial forever #4 core_clk = ~core_clk;
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // one edge, then settle
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   // one register access; a tick first so a strobe never falls and rises at once
   task automatic xfer(logic w, logic [7:0] a, logic [7:0] d);
      tick();
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
      tick();
      {reg_wr, reg_rd} = 2'b00;
      if (w && a == WSS_ADDR_SLOT4) m4 = d;
      if (w && a == WSS_ADDR_SLOT5) m5 = d;
      if (!w) chk("rdata", reg_rdata, a == WSS_ADDR_SLOT4 ? m4 : a == WSS_ADDR_SLOT5 ? m5 : 8'h00);
      if (!w) chk("hit", {7'h00, reg_hit}, {7'h00, a inside {WSS_ADDR_SLOT4, WSS_ADDR_SLOT5}});
      chk("slot four", slot_four, m4);
      chk("slot five", slot_five, m5);
   endtask
   function automatic wss_slot_t slot_of(int k);
      return k < 3 ? ext_slots[k] : k == 3 ? m4 : k == 4 ? m5 : ext_slots[k-2];
   endfunction
   // trigger, then follow each slot until the sequencer stops
   task automatic run;
      wss_slot_t s;
      tick();
      trigger = 1;
      tick();
      trigger = 0;
      chk("busy", {7'h00, seq_busy}, 8'h01);
      chk("index", {5'h00, slot_index}, 8'h00);
      for (int k = 0; k < WSS_NUM_SLOTS; k++) begin
         s = slot_of(k);
         if (s.value == WSS_VALUE_STOP) break;
         for (n = 0; n < 4 && !(play_start || idle_active); n++) tick();
         chk("index", {5'h00, slot_index}, 8'(k));
         chk("idle", {7'h00, idle_active}, {7'h00, s.delay_select});
         chk("play", {7'h00, play_start}, {7'h00, !s.delay_select});
         if (s.delay_select) begin
            for (n = 0; n < 2000 && idle_active; n++) tick();
            chk("idle len", 8'(n), 8'(s.value * STEP));
         end else begin
            chk("id", {1'b0, wave_id}, {1'b0, s.value});
            wave_done = 1;
            tick();
            wave_done = 0;
            chk("play pulse", {7'h00, play_start}, 8'h00);
         end
      end
      for (n = 0; n < 4 && seq_busy; n++) tick();
      chk("busy", {7'h00, seq_busy}, 8'h00);
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      #1;
      rst = 0;
      for (int i = 0; i < 20; i++) begin
         xfer(i > 1, {5'h02, 3'($random(seed))}, 8'($random(seed)));
         xfer(1'b0, {5'h02, 3'($random(seed))}, 8'h00);
      end
      $display("test registers done");
      for (int i = 0; i < 6; i++) ext_slots[i] = {1'b0, 7'($random(seed)) | 7'h01};
      xfer(1'b1, WSS_ADDR_SLOT4, {6'h20, 2'($random(seed)) | 2'h1}); // idle of 1 or 3 steps
      xfer(1'b1, WSS_ADDR_SLOT5, {1'b0, 7'($random(seed)) | 7'h01});
      run();
      $display("test eight slots done");
      xfer(1'b1, WSS_ADDR_SLOT5, 8'h80); // zero stops in idle mode too
      run();
      $display("test zero stop done");
      tally_and_finish();
   end
   // hang guard, well past the fewer than two hundred cycles needed
   initial begin
      #40000;
      bad_count++;
      tally_and_finish();
   end
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
endmodule // wss_slots_bench
